/* hdl/crs_pkg.sv */
// Constants and types shared by the core register set design files
// What this block does
// - Sixteen general registers; one to fifteen serve as data or address registers.
// - Register zero is the stack pointer, interrupt or user side per status bit.
// - Vector table base register supplies the base for interrupt vector lookup.
// - Program counter holds the address of the instruction now executing.
// - Status word holds instruction outcome flags and core state, including stack select.
// - Taking a fast interrupt copies the program counter into the backup counter.
// - Taking a fast interrupt copies the status word into the backup status word.
// - A fast interrupt branches to the fast interrupt vector register, not the table.
// - One 64-bit accumulator is destination and operand store for DSP instructions.
// - Multiply and multiply-accumulate instructions overwrite or accumulate onto the accumulator.
// - Accumulator writes go in halves: high loads 63..32, low loads 31..0.
// - Accumulator reads return 32 bits: high is 63..32, middle is 47..16.
package crs_pkg;

    localparam int unsigned DATA_W            = 32;
    localparam int unsigned ACCUM_W           = 64;
    localparam int unsigned GPR_IDX_W         = 4;
    localparam int unsigned FLAG_W            = 32;
    localparam int unsigned VEC_NUM_W         = 8;
    localparam int unsigned VEC_ENTRY_SHIFT   = 2;
    localparam int unsigned STATUS_STACK_BIT  = 16;
    localparam int unsigned ACCUM_HIGH_LSB    = 32;
    localparam int unsigned ACCUM_MIDDLE_LSB  = 16;
    localparam int unsigned ACCUM_LOW_LSB     = 0;

    localparam logic [GPR_IDX_W-1:0] GPR_STACK_IDX    = 4'h0;
    localparam logic                 STACK_SEL_INTR   = 1'b0;
    localparam logic                 STACK_SEL_USER   = 1'b1;
    localparam logic [DATA_W-1:0]    WORD_RESET_VAL   = 32'h00000000;
    localparam logic [ACCUM_W-1:0]   ACCUM_RESET_VAL  = 64'h0000000000000000;

    typedef enum logic [2:0] {
        CR_STATUS_WORD      = 3'h0,
        CR_PROGRAM_COUNTER  = 3'h1,
        CR_USER_STACK       = 3'h2,
        CR_FAST_VECTOR      = 3'h3,
        CR_INTR_STACK       = 3'h4,
        CR_VECTOR_BASE      = 3'h5,
        CR_BACKUP_STATUS    = 3'h6,
        CR_BACKUP_COUNTER   = 3'h7
    } crs_ctrl_sel_type;

    typedef enum logic [2:0] {
        ACCUM_OP_NONE        = 3'h0,
        ACCUM_OP_WRITE_HIGH  = 3'h1,
        ACCUM_OP_WRITE_LOW   = 3'h2,
        ACCUM_OP_PLAIN_MULT  = 3'h3,
        ACCUM_OP_SIGNED_EXT  = 3'h4,
        ACCUM_OP_UNSIGNED_EXT = 3'h5,
        ACCUM_OP_REPEAT_MAC  = 3'h6
    } crs_accum_op_type;

    typedef enum logic {
        ACCUM_RD_HIGH   = 1'b0,
        ACCUM_RD_MIDDLE = 1'b1
    } crs_accum_rd_type;

    typedef struct packed {
        logic [15:1][DATA_W-1:0] gpr;
        logic [DATA_W-1:0]       interrupt_stack_pointer;
        logic [DATA_W-1:0]       user_stack_pointer;
        logic [DATA_W-1:0]       vector_table_base;
        logic [DATA_W-1:0]       program_counter;
        logic [DATA_W-1:0]       processor_status_word;
        logic [DATA_W-1:0]       backup_program_counter;
        logic [DATA_W-1:0]       backup_status_word;
        logic [DATA_W-1:0]       fast_interrupt_vector;
        logic [ACCUM_W-1:0]      dsp_accumulator;
        logic [DATA_W-1:0]       rd_data_a;
        logic [DATA_W-1:0]       rd_data_b;
        logic [DATA_W-1:0]       ctrl_rd_data;
        logic [DATA_W-1:0]       accum_rd_data;
        logic [DATA_W-1:0]       vector_addr;
        logic                    vector_valid;
    } crs_state_type;

endpackage : crs_pkg

/* hdl/crs_accum_unit.sv */
// Next-value logic of the DSP accumulator
`timescale 1ns/100ps
module crs_accum_unit
    import crs_pkg::*;
(
    input  wire crs_accum_op_type       op,         // Accumulator operation
    input  wire logic [DATA_W-1:0]      src_a,      // First operand or write data
    input  wire logic [DATA_W-1:0]      src_b,      // Second operand
    input  wire logic [ACCUM_W-1:0]     accum_cur,  // Present accumulator value
    output logic      [ACCUM_W-1:0]     accum_nxt,  // Value to load
    output logic                        accum_we    // Load strobe
);
    logic signed [ACCUM_W-1:0] prod_signed;
    logic        [ACCUM_W-1:0] prod_unsigned;

    always_comb begin
        prod_signed   = $signed({{DATA_W{src_a[DATA_W-1]}}, src_a}) * $signed({{DATA_W{src_b[DATA_W-1]}}, src_b});
        prod_unsigned = {{DATA_W{1'b0}}, src_a} * {{DATA_W{1'b0}}, src_b};
        accum_nxt     = accum_cur;
        accum_we      = 1'b1;
        case (op)
            ACCUM_OP_WRITE_HIGH: begin
                accum_nxt = {src_a, accum_cur[ACCUM_HIGH_LSB-1:ACCUM_LOW_LSB]};
            end
            ACCUM_OP_WRITE_LOW: begin
                accum_nxt = {accum_cur[ACCUM_W-1:ACCUM_HIGH_LSB], src_a};
            end
            ACCUM_OP_PLAIN_MULT: begin
                // Low word of the product, sign extended
                accum_nxt = {{DATA_W{prod_signed[DATA_W-1]}}, prod_signed[DATA_W-1:0]};
            end
            ACCUM_OP_SIGNED_EXT: begin
                accum_nxt = prod_signed;
            end
            ACCUM_OP_UNSIGNED_EXT: begin
                accum_nxt = prod_unsigned;
            end
            ACCUM_OP_REPEAT_MAC: begin
                accum_nxt = accum_cur + prod_signed;
            end
            default: begin
                accum_we  = 1'b0;
            end
        endcase
    end

endmodule : crs_accum_unit

/* hdl/crs_core_regs.sv */
// Architectural register set of the CPU core
`timescale 1ns/100ps
module crs_core_regs
    import crs_pkg::*;
(
    input  wire logic                   CLK,                // 50 MHz core clock
    input  wire logic                   NRST,               // Asynchronous reset, active low
    input  wire logic                   GPR_WR_EN,          // General register write strobe
    input  wire logic [GPR_IDX_W-1:0]   GPR_WR_IDX,         // General register write index
    input  wire logic [DATA_W-1:0]      GPR_WR_DATA,        // General register write data
    input  wire logic [GPR_IDX_W-1:0]   GPR_RD_IDX_A,       // Read port A index
    input  wire logic [GPR_IDX_W-1:0]   GPR_RD_IDX_B,       // Read port B index
    output logic      [DATA_W-1:0]      GPR_RD_DATA_A,      // Read port A data, one cycle later
    output logic      [DATA_W-1:0]      GPR_RD_DATA_B,      // Read port B data, one cycle later
    input  wire logic                   CTRL_WR_EN,         // Control register write strobe
    input  wire crs_ctrl_sel_type       CTRL_WR_SEL,        // Control register write select
    input  wire logic [DATA_W-1:0]      CTRL_WR_DATA,       // Control register write data
    input  wire crs_ctrl_sel_type       CTRL_RD_SEL,        // Control register read select
    output logic      [DATA_W-1:0]      CTRL_RD_DATA,       // Control register read data
    input  wire logic                   FLAG_UPD_EN,        // Status flag update strobe
    input  wire logic [FLAG_W-1:0]      FLAG_UPD_MASK,      // Status bits to update
    input  wire logic [FLAG_W-1:0]      FLAG_UPD_DATA,      // New status bit values
    input  wire logic                   COUNTER_LOAD_EN,    // Program counter load strobe
    input  wire logic [DATA_W-1:0]      COUNTER_LOAD_VALUE, // Address of next instruction
    input  wire logic                   FAST_INT_TAKE,      // Fast interrupt accepted
    input  wire logic                   VEC_REQ,            // Table vector address request
    input  wire logic [VEC_NUM_W-1:0]   VEC_NUM,            // Vector number
    output logic      [DATA_W-1:0]      VEC_ADDR,           // Table entry address
    output logic                        VEC_VALID,          // Table entry address valid
    input  wire crs_accum_op_type       ACCUM_OP,           // Accumulator operation
    input  wire logic [DATA_W-1:0]      ACCUM_SRC_A,        // Operand A or write data
    input  wire logic [DATA_W-1:0]      ACCUM_SRC_B,        // Operand B
    input  wire crs_accum_rd_type       ACCUM_RD_SEL,       // Accumulator read slice
    output logic      [DATA_W-1:0]      ACCUM_RD_DATA,      // Accumulator read slice data
    output logic      [DATA_W-1:0]      PROGRAM_COUNTER,    // Address of executing instruction
    output logic      [DATA_W-1:0]      STATUS_WORD,        // Processor status word
    output logic                        STACK_SEL           // High when user stack is active
);

    crs_state_type          cur_ff;
    crs_state_type          nxt_state;
    logic [ACCUM_W-1:0]     accum_calc;
    logic                   accum_calc_we;

    // Stack side chosen by the registered status word only
    function automatic logic stack_is_user(input logic [DATA_W-1:0] status);
        stack_is_user = (status[STATUS_STACK_BIT] == STACK_SEL_USER);
    endfunction : stack_is_user

    // General register read, register zero through the active stack pointer
    function automatic logic [DATA_W-1:0] read_gpr(
        input crs_state_type        st,
        input logic [GPR_IDX_W-1:0] idx
    );
        if (idx == GPR_STACK_IDX) begin
            if (stack_is_user(st.processor_status_word)) begin
                read_gpr = st.user_stack_pointer;
            end else begin
                read_gpr = st.interrupt_stack_pointer;
            end
        end else begin
            read_gpr = st.gpr[idx];
        end
    endfunction : read_gpr

    // Control register read
    function automatic logic [DATA_W-1:0] read_ctrl(
        input crs_state_type    st,
        input crs_ctrl_sel_type sel
    );
        if (sel == CR_STATUS_WORD) begin
            read_ctrl = st.processor_status_word;
        end else if (sel == CR_PROGRAM_COUNTER) begin
            read_ctrl = st.program_counter;
        end else if (sel == CR_USER_STACK) begin
            read_ctrl = st.user_stack_pointer;
        end else if (sel == CR_FAST_VECTOR) begin
            read_ctrl = st.fast_interrupt_vector;
        end else if (sel == CR_INTR_STACK) begin
            read_ctrl = st.interrupt_stack_pointer;
        end else if (sel == CR_VECTOR_BASE) begin
            read_ctrl = st.vector_table_base;
        end else if (sel == CR_BACKUP_STATUS) begin
            read_ctrl = st.backup_status_word;
        end else begin
            read_ctrl = st.backup_program_counter;
        end
    endfunction : read_ctrl

    crs_accum_unit u_accum_unit (
        .op        (ACCUM_OP),
        .src_a     (ACCUM_SRC_A),
        .src_b     (ACCUM_SRC_B),
        .accum_cur (cur_ff.dsp_accumulator),
        .accum_nxt (accum_calc),
        .accum_we  (accum_calc_we)
    );

    always_comb begin
        nxt_state = cur_ff;

        // General register write; register zero lands in the selected stack pointer
        if (GPR_WR_EN) begin
            if (GPR_WR_IDX == GPR_STACK_IDX) begin
                if (stack_is_user(cur_ff.processor_status_word)) begin
                    nxt_state.user_stack_pointer = GPR_WR_DATA;
                end else begin
                    nxt_state.interrupt_stack_pointer = GPR_WR_DATA;
                end
            end else begin
                nxt_state.gpr[GPR_WR_IDX] = GPR_WR_DATA;
            end
        end

        // Control register write, later in order so it wins over a general write
        if (CTRL_WR_EN) begin
            case (CTRL_WR_SEL)
                CR_STATUS_WORD: begin
                    nxt_state.processor_status_word = CTRL_WR_DATA;
                end
                CR_PROGRAM_COUNTER: begin
                    nxt_state.program_counter = CTRL_WR_DATA;
                end
                CR_USER_STACK: begin
                    nxt_state.user_stack_pointer = CTRL_WR_DATA;
                end
                CR_FAST_VECTOR: begin
                    nxt_state.fast_interrupt_vector = CTRL_WR_DATA;
                end
                CR_INTR_STACK: begin
                    nxt_state.interrupt_stack_pointer = CTRL_WR_DATA;
                end
                CR_VECTOR_BASE: begin
                    nxt_state.vector_table_base = CTRL_WR_DATA;
                end
                CR_BACKUP_STATUS: begin
                    nxt_state.backup_status_word = CTRL_WR_DATA;
                end
                default: begin
                    nxt_state.backup_program_counter = CTRL_WR_DATA;
                end
            endcase
        end

        // Instruction outcome flags, only the masked bits move
        if (FLAG_UPD_EN) begin
            nxt_state.processor_status_word = (nxt_state.processor_status_word & ~FLAG_UPD_MASK)
                                            | (FLAG_UPD_DATA & FLAG_UPD_MASK);
        end

        // Program counter follows the sequencer
        if (COUNTER_LOAD_EN) begin
            nxt_state.program_counter = COUNTER_LOAD_VALUE;
        end

        // Fast interrupt overrides every other update of these registers
        if (FAST_INT_TAKE) begin
            nxt_state.backup_program_counter = cur_ff.program_counter;
            nxt_state.backup_status_word     = cur_ff.processor_status_word;
            nxt_state.program_counter        = cur_ff.fast_interrupt_vector;
            nxt_state.processor_status_word  = cur_ff.processor_status_word;
            nxt_state.processor_status_word[STATUS_STACK_BIT] = STACK_SEL_INTR;
        end

        // Table vector address from the relocatable base
        nxt_state.vector_valid = VEC_REQ;
        if (VEC_REQ) begin
            nxt_state.vector_addr = cur_ff.vector_table_base
                                  + (DATA_W'(VEC_NUM) << VEC_ENTRY_SHIFT);
        end

        // Accumulator update from the arithmetic unit
        if (accum_calc_we) begin
            nxt_state.dsp_accumulator = accum_calc;
        end

        // Registered read ports see the values before this cycle's writes
        nxt_state.rd_data_a    = read_gpr(cur_ff, GPR_RD_IDX_A);
        nxt_state.rd_data_b    = read_gpr(cur_ff, GPR_RD_IDX_B);
        nxt_state.ctrl_rd_data = read_ctrl(cur_ff, CTRL_RD_SEL);
        if (ACCUM_RD_SEL == ACCUM_RD_HIGH) begin
            nxt_state.accum_rd_data = cur_ff.dsp_accumulator[ACCUM_HIGH_LSB +: DATA_W];
        end else begin
            nxt_state.accum_rd_data = cur_ff.dsp_accumulator[ACCUM_MIDDLE_LSB +: DATA_W];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cur_ff.gpr                     <= '0;
            cur_ff.interrupt_stack_pointer <= WORD_RESET_VAL;
            cur_ff.user_stack_pointer      <= WORD_RESET_VAL;
            cur_ff.vector_table_base       <= WORD_RESET_VAL;
            cur_ff.program_counter         <= WORD_RESET_VAL;
            cur_ff.processor_status_word   <= WORD_RESET_VAL;
            cur_ff.backup_program_counter  <= WORD_RESET_VAL;
            cur_ff.backup_status_word      <= WORD_RESET_VAL;
            cur_ff.fast_interrupt_vector   <= WORD_RESET_VAL;
            cur_ff.dsp_accumulator         <= ACCUM_RESET_VAL;
            cur_ff.rd_data_a               <= WORD_RESET_VAL;
            cur_ff.rd_data_b               <= WORD_RESET_VAL;
            cur_ff.ctrl_rd_data            <= WORD_RESET_VAL;
            cur_ff.accum_rd_data           <= WORD_RESET_VAL;
            cur_ff.vector_addr             <= WORD_RESET_VAL;
            cur_ff.vector_valid            <= 1'b0;
        end else begin
            cur_ff <= nxt_state;
        end
    end

    assign GPR_RD_DATA_A   = cur_ff.rd_data_a;
    assign GPR_RD_DATA_B   = cur_ff.rd_data_b;
    assign CTRL_RD_DATA    = cur_ff.ctrl_rd_data;
    assign VEC_ADDR        = cur_ff.vector_addr;
    assign VEC_VALID       = cur_ff.vector_valid;
    assign ACCUM_RD_DATA   = cur_ff.accum_rd_data;
    assign PROGRAM_COUNTER = cur_ff.program_counter;
    assign STATUS_WORD     = cur_ff.processor_status_word;
    assign STACK_SEL       = cur_ff.processor_status_word[STATUS_STACK_BIT];

endmodule : crs_core_regs

/* bench/crs_core_regs_assertions.sv */
// Port-level checker for the core register set
`timescale 1ns/100ps
module crs_core_regs_assertions
    import crs_pkg::*;
(
    input wire logic                 CLK,                // Core clock
    input wire logic                 NRST,               // Reset, active low
    input wire logic                 CTRL_WR_EN,         // Control write strobe
    input wire crs_ctrl_sel_type     CTRL_RD_SEL,        // Control read select
    input wire logic [DATA_W-1:0]    CTRL_RD_DATA,       // Control read data
    input wire logic                 FLAG_UPD_EN,        // Flag update strobe
    input wire logic [FLAG_W-1:0]    FLAG_UPD_MASK,      // Flag mask
    input wire logic [FLAG_W-1:0]    FLAG_UPD_DATA,      // Flag data
    input wire logic                 COUNTER_LOAD_EN,    // Counter load strobe
    input wire logic [DATA_W-1:0]    COUNTER_LOAD_VALUE, // Counter load value
    input wire logic                 FAST_INT_TAKE,      // Fast interrupt pulse
    input wire logic                 VEC_REQ,            // Vector request
    input wire logic                 VEC_VALID,          // Vector valid
    input wire crs_accum_op_type     ACCUM_OP,           // Accumulator operation
    input wire logic [DATA_W-1:0]    ACCUM_SRC_A,        // Accumulator operand
    input wire crs_accum_rd_type     ACCUM_RD_SEL,       // Accumulator read slice
    input wire logic [DATA_W-1:0]    ACCUM_RD_DATA,      // Accumulator read data
    input wire logic [DATA_W-1:0]    PROGRAM_COUNTER,    // Program counter
    input wire logic [DATA_W-1:0]    STATUS_WORD,        // Status word
    input wire logic                 STACK_SEL           // Stack select
);
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    property p_stack_mirror;
        STACK_SEL == STATUS_WORD[STATUS_STACK_BIT];
    endproperty
    a_stack_mirror: assert property (p_stack_mirror) else $error("Stack select differs from status bit");
    property p_fast_bpc;
        FAST_INT_TAKE ##1 CTRL_RD_SEL == CR_BACKUP_COUNTER |=> CTRL_RD_DATA == $past(PROGRAM_COUNTER, 2);
    endproperty
    a_fast_bpc: assert property (p_fast_bpc) else $error("Backup counter lost old counter");
    property p_fast_backup_status_word;
        FAST_INT_TAKE ##1 CTRL_RD_SEL == CR_BACKUP_STATUS |=> CTRL_RD_DATA == $past(STATUS_WORD, 2);
    endproperty
    a_fast_backup_status_word: assert property (p_fast_backup_status_word) else $error("Backup status lost old status");
    property p_fast_vector;
        (CTRL_RD_SEL == CR_FAST_VECTOR && !CTRL_WR_EN) ##1 FAST_INT_TAKE
            |=> PROGRAM_COUNTER == $past(CTRL_RD_DATA) && !STACK_SEL;
    endproperty
    a_fast_vector: assert property (p_fast_vector) else $error("Fast interrupt branch target wrong");
    property p_pc_load;
        COUNTER_LOAD_EN && !FAST_INT_TAKE |=> PROGRAM_COUNTER == $past(COUNTER_LOAD_VALUE);
    endproperty
    a_pc_load: assert property (p_pc_load) else $error("Program counter load missed");
    property p_flag_upd;
        FLAG_UPD_EN && !FAST_INT_TAKE && !CTRL_WR_EN |=> STATUS_WORD ==
            (($past(STATUS_WORD) & ~$past(FLAG_UPD_MASK)) | ($past(FLAG_UPD_DATA) & $past(FLAG_UPD_MASK)));
    endproperty
    a_flag_upd: assert property (p_flag_upd) else $error("Status flag update wrong");
    property p_vec_valid;
        1'b1 |=> VEC_VALID == $past(VEC_REQ);
    endproperty
    a_vec_valid: assert property (p_vec_valid) else $error("Vector valid timing wrong");
    property p_acc_high;
        ACCUM_OP == ACCUM_OP_WRITE_HIGH ##1 (ACCUM_OP == ACCUM_OP_NONE && ACCUM_RD_SEL == ACCUM_RD_HIGH)
            |=> ACCUM_RD_DATA == $past(ACCUM_SRC_A, 2);
    endproperty
    a_acc_high: assert property (p_acc_high) else $error("Accumulator high half wrong");
    c_fast: cover property (FAST_INT_TAKE);
    c_vec: cover property (VEC_VALID);
    c_mac: cover property (ACCUM_OP == ACCUM_OP_REPEAT_MAC);
endmodule : crs_core_regs_assertions

bind crs_core_regs crs_core_regs_assertions chk_u (.*);

/* bench/crs_exec_model.sv */
// Interrupt sequencer model issuing fast interrupt acceptance pulses
`timescale 1ns/100ps
module crs_exec_model (
    input  wire logic clk,        // Core clock
    input  wire logic nrst,       // Reset, active low
    input  wire logic fire,       // Acceptance request from the bench
    output logic      take_pulse  // One-cycle acceptance pulse
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) take_pulse <= 1'b0;
        else take_pulse <= fire && !take_pulse;
    end
endmodule : crs_exec_model

/* bench/tb.sv */
// Self-checking bench for the core register set
`timescale 1ns/100ps
module tb;
    import crs_pkg::*;
    logic CLK, NRST, GPR_WR_EN, CTRL_WR_EN, FLAG_UPD_EN, COUNTER_LOAD_EN, FAST_INT_TAKE, fire;
    logic VEC_REQ, VEC_VALID, STACK_SEL;
    logic [GPR_IDX_W-1:0] GPR_WR_IDX, GPR_RD_IDX_A, GPR_RD_IDX_B;
    logic [DATA_W-1:0] GPR_WR_DATA, GPR_RD_DATA_A, GPR_RD_DATA_B, CTRL_WR_DATA, CTRL_RD_DATA, COUNTER_LOAD_VALUE;
    logic [DATA_W-1:0] VEC_ADDR, ACCUM_SRC_A, ACCUM_SRC_B, ACCUM_RD_DATA, PROGRAM_COUNTER, STATUS_WORD;
    logic [FLAG_W-1:0] FLAG_UPD_MASK, FLAG_UPD_DATA;
    logic [VEC_NUM_W-1:0] VEC_NUM;
    crs_ctrl_sel_type CTRL_WR_SEL, CTRL_RD_SEL;
    crs_accum_op_type ACCUM_OP;
    crs_accum_rd_type ACCUM_RD_SEL;
    int miscompares = 0;
    int checks_done = 0;
    logic [ACCUM_W-1:0] acc_exp, sp, up;
    crs_accum_op_type ops [4] = '{ACCUM_OP_REPEAT_MAC, ACCUM_OP_PLAIN_MULT, ACCUM_OP_SIGNED_EXT, ACCUM_OP_UNSIGNED_EXT};
    crs_core_regs dut_u (.*);
    crs_exec_model exec_u (.clk(CLK), .nrst(NRST), .fire(fire), .take_pulse(FAST_INT_TAKE));
    initial CLK = 1'b0;
    always #10 CLK = ~CLK;
    task automatic chk(input string name, input logic [ACCUM_W-1:0] seen, input logic [ACCUM_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        $display("Checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done
    task automatic gw(input logic [GPR_IDX_W-1:0] i, input logic [DATA_W-1:0] d);
        @(posedge CLK);
        GPR_WR_EN <= 1'b1;
        GPR_WR_IDX <= i;
        GPR_WR_DATA <= d;
        @(posedge CLK);
        GPR_WR_EN <= 1'b0;
    endtask : gw
    task automatic gr(input logic [GPR_IDX_W-1:0] i, input logic [DATA_W-1:0] e);
        @(posedge CLK);
        GPR_RD_IDX_A <= i;
        GPR_RD_IDX_B <= i;
        @(posedge CLK);
        #1;
        chk("gpr_port_a", GPR_RD_DATA_A, e);
        chk("gpr_port_b", GPR_RD_DATA_B, e);
    endtask : gr
    task automatic cw(input crs_ctrl_sel_type s, input logic [DATA_W-1:0] d);
        @(posedge CLK);
        CTRL_WR_EN <= 1'b1;
        CTRL_WR_SEL <= s;
        CTRL_WR_DATA <= d;
        @(posedge CLK);
        CTRL_WR_EN <= 1'b0;
    endtask : cw
    task automatic cr(input crs_ctrl_sel_type s, input logic [DATA_W-1:0] e);
        @(posedge CLK);
        CTRL_RD_SEL <= s;
        @(posedge CLK);
        #1;
        chk(s.name(), CTRL_RD_DATA, e);
    endtask : cr
    task automatic fu(input logic [FLAG_W-1:0] m, input logic [FLAG_W-1:0] d);
        @(posedge CLK);
        FLAG_UPD_EN <= 1'b1;
        FLAG_UPD_MASK <= m;
        FLAG_UPD_DATA <= d;
        @(posedge CLK);
        FLAG_UPD_EN <= 1'b0;
    endtask : fu
    task automatic ao(input crs_accum_op_type op, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        @(posedge CLK);
        ACCUM_OP <= op;
        ACCUM_SRC_A <= a;
        ACCUM_SRC_B <= b;
        @(posedge CLK);
        ACCUM_OP <= ACCUM_OP_NONE;
    endtask : ao
    task automatic ar(input logic [ACCUM_W-1:0] e);
        @(posedge CLK);
        ACCUM_RD_SEL <= ACCUM_RD_HIGH;
        @(posedge CLK);
        ACCUM_RD_SEL <= ACCUM_RD_MIDDLE;
        #1;
        chk("accum_high", ACCUM_RD_DATA, e[63:32]);
        @(posedge CLK);
        #1;
        chk("accum_middle", ACCUM_RD_DATA, e[47:16]);
    endtask : ar
    initial begin
        {GPR_WR_EN, CTRL_WR_EN, FLAG_UPD_EN, COUNTER_LOAD_EN, VEC_REQ, fire} = '0;
        {GPR_WR_IDX, GPR_RD_IDX_A, GPR_RD_IDX_B, GPR_WR_DATA, CTRL_WR_DATA, COUNTER_LOAD_VALUE} = '0;
        {FLAG_UPD_MASK, FLAG_UPD_DATA, VEC_NUM, ACCUM_SRC_A, ACCUM_SRC_B} = '0;
        CTRL_WR_SEL = CR_STATUS_WORD;
        CTRL_RD_SEL = CR_STATUS_WORD;
        ACCUM_OP = ACCUM_OP_NONE;
        ACCUM_RD_SEL = ACCUM_RD_HIGH;
        NRST = 1'b0;
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        cr(CR_PROGRAM_COUNTER, 32'h00000000);
        chk("stack_sel", STACK_SEL, 1'b0);
        $display("Test reset done");
        for (int i = 1; i < 16; i++) gw(i[3:0], 32'hA5000000 | i);
        for (int i = 1; i < 16; i++) gr(i[3:0], 32'hA5000000 | i);
        $display("Test general registers done");
        gw(4'h0, 32'h00001000);
        cr(CR_INTR_STACK, 32'h00001000);
        fu(32'h00010000, 32'h00010000);
        #1;
        chk("stack_sel_user", STACK_SEL, 1'b1);
        gw(4'h0, 32'h00002000);
        cr(CR_USER_STACK, 32'h00002000);
        cr(CR_INTR_STACK, 32'h00001000);
        gr(4'h0, 32'h00002000);
        $display("Test stack pointers done");
        for (int s = 0; s < 8; s++) cw(crs_ctrl_sel_type'(s[2:0]), 32'h11000000 + 32'(s * 16));
        for (int s = 0; s < 8; s++) cr(crs_ctrl_sel_type'(s[2:0]), 32'h11000000 + 32'(s * 16));
        $display("Test control registers done");
        @(posedge CLK);
        VEC_REQ <= 1'b1;
        VEC_NUM <= 8'hFF;
        @(posedge CLK);
        VEC_REQ <= 1'b0;
        #1;
        chk("vec_valid", VEC_VALID, 1'b1);
        chk("vec_addr", VEC_ADDR, 32'h11000050 + 32'h000003FC);
        @(posedge CLK);
        #1;
        chk("vec_valid_low", VEC_VALID, 1'b0);
        $display("Test vector lookup done");
        @(posedge CLK);
        COUNTER_LOAD_EN <= 1'b1;
        COUNTER_LOAD_VALUE <= 32'h00004000;
        @(posedge CLK);
        COUNTER_LOAD_EN <= 1'b0;
        fu(32'hFFFFFFFF, 32'h80010005);
        cw(CR_FAST_VECTOR, 32'h00007000);
        @(posedge CLK);
        fire <= 1'b1;
        CTRL_RD_SEL <= CR_FAST_VECTOR;
        @(posedge CLK);
        fire <= 1'b0;
        @(posedge CLK);
        CTRL_RD_SEL <= CR_BACKUP_COUNTER;
        @(posedge CLK);
        #1;
        chk("fast_pc", PROGRAM_COUNTER, 32'h00007000);
        chk("fast_stack_sel", STACK_SEL, 1'b0);
        chk("fast_status", STATUS_WORD, 32'h80000005);
        @(posedge CLK);
        #1;
        chk("backup_counter", CTRL_RD_DATA, 32'h00004000);
        cr(CR_BACKUP_STATUS, 32'h80010005);
        // Second fast interrupt, backup status selected in the same cycle as the pulse
        @(posedge CLK);
        fire <= 1'b1;
        @(posedge CLK);
        fire <= 1'b0;
        CTRL_RD_SEL <= CR_BACKUP_STATUS;
        repeat (3) @(posedge CLK);
        #1;
        chk("backup_status_nested", CTRL_RD_DATA, 32'h80000005);
        $display("Test fast interrupt done");
        ao(ACCUM_OP_WRITE_HIGH, 32'h12345678, 32'h00000000);
        ao(ACCUM_OP_WRITE_LOW, 32'h9ABCDEF0, 32'h00000000);
        acc_exp = 64'h123456789ABCDEF0;
        ar(acc_exp);
        sp = longint'(signed'(32'h80000001)) * longint'(signed'(32'h00000004));
        up = {32'h00000000, 32'h80000001} * {32'h00000000, 32'h00000004};
        foreach (ops[k]) begin
            ao(ops[k], 32'h80000001, 32'h00000004);
            case (ops[k])
                ACCUM_OP_REPEAT_MAC: acc_exp = acc_exp + sp;
                ACCUM_OP_PLAIN_MULT: acc_exp = {{32{sp[31]}}, sp[31:0]};
                ACCUM_OP_SIGNED_EXT: acc_exp = sp;
                default: acc_exp = up;
            endcase
            ar(acc_exp);
        end
        $display("Test accumulator done");
        test_done();
    end
    initial begin
        // Whole sequence needs well under 20 us
        #100us;
        miscompares++;
        test_done();
    end
endmodule : tb
